// *** verilog/djk_pkg.sv ***
// Package for the dual J-K bistable block: variants and clock-edge states.
// Assumes one system clock; all device pins arrive asynchronously.
package djk_pkg;
	localparam int unsigned NUM_BITS     = 2;
	localparam int unsigned SYNC_STAGES  = 2;
	localparam logic        RESET_STATE  = 1'b0;
	localparam logic        PIN_ACTIVE_N = 1'b0;
	// Variant select: individual clocks and presets, or shared clock and clear
	typedef enum logic {
		DJK_VAR_INDIV,
		DJK_VAR_SHARED
	} djk_variant_e;
	// Phase of a pin clock, low or high; arming reads the clock level directly, not this type
	typedef enum logic [1:0] {
		DJK_CLK_LOW,
		DJK_CLK_HIGH
	} djk_clkphase_e;
endpackage

// *** verilog/djk_sync.sv ***
// Two-flop synchroniser bank for asynchronous pins.
// Assumes the pins are stable relative to the clock only after two stages.
`timescale 1ns/100ps
module djk_sync #(
	parameter int unsigned WIDTH = 1
) (
	// System
	input  wire logic             clock,
	input  wire logic             reset,
	// Pins and synchronised copies
	input  wire logic [WIDTH-1:0] pinIn,
	output logic      [WIDTH-1:0] syncOut
);
	import djk_pkg::*;

	logic [WIDTH-1:0] stage1_ff;
	logic [WIDTH-1:0] stage2_ff;

	// Reset loads ones, the idle level of the clock and active-low pins, so no false edge follows release
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			always_ff @(posedge clock or posedge reset) begin
				if (reset) begin
					stage1_ff[g] <= 1'b1;
					stage2_ff[g] <= 1'b1;
				end else begin
					stage1_ff[g] <= pinIn[g];
					stage2_ff[g] <= stage1_ff[g];
				end
			end
		end
	endgenerate

	assign syncOut = stage2_ff;
endmodule

// *** verilog/djk_dual_flop.sv ***
// Dual J-K bistable with falling-edge commit, asynchronous-style preset/clear.
// Assumes all pins come from outside the clock domain; one system clock samples them.
`timescale 1ns/100ps
module djk_dual_flop (
	// System
	input  wire logic                           clock,
	input  wire logic                           reset,
	// Variant strap
	input  wire logic                           variantShared,
	// Steering pins
	input  wire logic [djk_pkg::NUM_BITS-1:0]   jIn,
	input  wire logic [djk_pkg::NUM_BITS-1:0]   kIn,
	// Clock pins; clkIn[0] is the shared clock in the shared variant
	input  wire logic [djk_pkg::NUM_BITS-1:0]   clkIn,
	// Asynchronous controls, active low
	input  wire logic [djk_pkg::NUM_BITS-1:0]   presetN,
	input  wire logic                           clearN,
	// Outputs
	output logic      [djk_pkg::NUM_BITS-1:0]   qOut,
	output logic      [djk_pkg::NUM_BITS-1:0]   qOutN
);
	import djk_pkg::*;

	// Strap rides in the top bit of the synchroniser bank
	localparam int unsigned PIN_W      = 4 * NUM_BITS + 2;
	localparam logic [1:0]  STRAP_WAIT = 2'(SYNC_STAGES);

	logic [PIN_W-1:0]    pinBus;
	logic [PIN_W-1:0]    pinSync;
	logic [NUM_BITS-1:0] jS;
	logic [NUM_BITS-1:0] kS;
	logic [NUM_BITS-1:0] clkS;
	logic [NUM_BITS-1:0] presetSN;
	logic                clearSN;
	logic                strapS;
	logic                sharedMode_ff;
	logic [1:0]          strapCnt_ff;
	logic                strapTaken_ff;

	assign pinBus = {variantShared, clearN, presetN, clkIn, kIn, jIn};

	djk_sync #(
		.WIDTH(PIN_W)
	) djk_sync_i (
		.clock   (clock),
		.reset   (reset),
		.pinIn   (pinBus),
		.syncOut (pinSync)
	);

	assign jS       = pinSync[NUM_BITS-1:0];
	assign kS       = pinSync[2*NUM_BITS-1:NUM_BITS];
	assign clkS     = pinSync[3*NUM_BITS-1:2*NUM_BITS];
	assign presetSN = pinSync[4*NUM_BITS-1:3*NUM_BITS];
	assign clearSN  = pinSync[4*NUM_BITS];
	assign strapS   = pinSync[4*NUM_BITS+1];

	// Strap is taken once the synchroniser holds the real level, not its reset fill;
	// later strap changes are ignored until the next reset
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			sharedMode_ff <= 1'b0;
			strapCnt_ff   <= 2'h0;
			strapTaken_ff <= 1'b0;
		end else if (!strapTaken_ff) begin
			if (strapCnt_ff == STRAP_WAIT) begin
				sharedMode_ff <= strapS;
				strapTaken_ff <= 1'b1;
			end else begin
				strapCnt_ff <= strapCnt_ff + 2'h1;
			end
		end
	end

	function automatic logic jkNext(input logic j, input logic k, input logic q);
		case ({j, k})
			2'b00:   jkNext = q;
			2'b01:   jkNext = 1'b0;
			2'b10:   jkNext = 1'b1;
			2'b11:   jkNext = ~q;
			default: jkNext = q;
		endcase
	endfunction

	logic [NUM_BITS-1:0] state_ff;
	logic [NUM_BITS-1:0] clkPrev_ff;
	logic [NUM_BITS-1:0] armed_ff;
	logic [NUM_BITS-1:0] effClk;
	logic [NUM_BITS-1:0] fallEdge;
	logic [NUM_BITS-1:0] forceHigh;
	logic [NUM_BITS-1:0] forceLow;
	logic [NUM_BITS-1:0] nxt_state;

	genvar g;
	generate
		for (g = 0; g < NUM_BITS; g++) begin : g_flop
			// Shared variant routes clock pin 0 to both halves
			assign effClk[g]    = sharedMode_ff ? clkS[0] : clkS[g];
			assign fallEdge[g]  = clkPrev_ff[g] & ~effClk[g] & armed_ff[g];
			assign forceHigh[g] = (presetSN[g] == PIN_ACTIVE_N);
			// Clear exists only in the shared variant
			assign forceLow[g]  = sharedMode_ff & (clearSN == PIN_ACTIVE_N);
			assign nxt_state[g] = forceHigh[g] ? 1'b1 :
			                      forceLow[g]  ? 1'b0 :
			                      fallEdge[g]  ? jkNext(jS[g], kS[g], state_ff[g]) :
			                      state_ff[g];

			always_ff @(posedge clock or posedge reset) begin
				if (reset) begin
					state_ff[g]   <= RESET_STATE;
					clkPrev_ff[g] <= 1'b1;
					armed_ff[g]   <= 1'b0;
				end else begin
					state_ff[g]   <= nxt_state[g];
					clkPrev_ff[g] <= effClk[g];
					// A fall only counts after the clock was seen high
					armed_ff[g]   <= effClk[g] ? 1'b1 : (fallEdge[g] ? 1'b0 : armed_ff[g]);
				end
			end

			// Both outputs registered so they always stay complementary
			always_ff @(posedge clock or posedge reset) begin
				if (reset) begin
					qOut[g]  <= RESET_STATE;
					qOutN[g] <= ~RESET_STATE;
				end else begin
					qOut[g]  <= nxt_state[g];
					qOutN[g] <= ~nxt_state[g];
				end
			end
		end
	endgenerate

	// Both preset and clear low gives preset priority, so the true output reads high

	// Output pairing and variant strap
	a_out_compl: assert property (@(posedge clock) disable iff (reset) qOutN == ~qOut)
		else $error("outputs not complementary");
	a_strap_hold: assert property (@(posedge clock) disable iff (reset)
		strapTaken_ff |=> $stable(sharedMode_ff))
		else $error("variant changed after capture");

	// Asynchronous controls
	a_preset_high: assert property (@(posedge clock) disable iff (reset)
		forceHigh[0] |=> qOut[0])
		else $error("preset did not force high");
	a_preset_bit1: assert property (@(posedge clock) disable iff (reset)
		forceHigh[1] |=> qOut[1])
		else $error("preset did not force bit one high");
	a_clear_low: assert property (@(posedge clock) disable iff (reset)
		(forceLow[1] && !forceHigh[1]) |=> !qOut[1])
		else $error("clear did not force low");
	a_clear_bit0: assert property (@(posedge clock) disable iff (reset)
		(forceLow[0] && !forceHigh[0]) |=> !qOut[0])
		else $error("clear did not force bit zero low");

	// Commit only on a qualified falling edge
	a_hold_noedge: assert property (@(posedge clock) disable iff (reset)
		(!fallEdge[0] && !forceHigh[0] && !forceLow[0]) |=> $stable(state_ff[0]))
		else $error("state changed without falling edge");
	a_hold_bit1: assert property (@(posedge clock) disable iff (reset)
		(!fallEdge[1] && !forceHigh[1] && !forceLow[1]) |=> $stable(state_ff[1]))
		else $error("bit one changed without falling edge");
	a_hold_outputs: assert property (@(posedge clock) disable iff (reset)
		(!fallEdge[0] && !forceHigh[0] && !forceLow[0]) |=> $stable(qOut[0]))
		else $error("output changed without falling edge");
	a_fall_once: assert property (@(posedge clock) disable iff (reset)
		fallEdge[0] |=> !fallEdge[0])
		else $error("one falling edge counted twice");
	a_fall_bit1: assert property (@(posedge clock) disable iff (reset)
		fallEdge[1] |=> !fallEdge[1])
		else $error("bit one falling edge counted twice");
	a_arm_before: assert property (@(posedge clock) disable iff (reset)
		fallEdge[0] |-> $past(effClk[0]))
		else $error("edge without prior high clock");

	// Truth table on both halves
	a_toggle_case: assert property (@(posedge clock) disable iff (reset)
		(fallEdge[0] && jS[0] && kS[0] && !forceHigh[0] && !forceLow[0]) |=> state_ff[0] != $past(state_ff[0]))
		else $error("toggle failed");
	a_toggle_bit1: assert property (@(posedge clock) disable iff (reset)
		(fallEdge[1] && jS[1] && kS[1] && !forceHigh[1] && !forceLow[1]) |=> state_ff[1] != $past(state_ff[1]))
		else $error("bit one toggle failed");
	a_set_case: assert property (@(posedge clock) disable iff (reset)
		(fallEdge[1] && jS[1] && !kS[1] && !forceLow[1]) |=> state_ff[1])
		else $error("set failed");
	a_set_bit0: assert property (@(posedge clock) disable iff (reset)
		(fallEdge[0] && jS[0] && !kS[0] && !forceLow[0]) |=> state_ff[0])
		else $error("bit zero set failed");
	a_reset_case: assert property (@(posedge clock) disable iff (reset)
		(fallEdge[1] && !jS[1] && kS[1] && !forceHigh[1] && !forceLow[1]) |=> !state_ff[1])
		else $error("reset case failed");
	a_reset_bit0: assert property (@(posedge clock) disable iff (reset)
		(fallEdge[0] && !jS[0] && kS[0] && !forceHigh[0] && !forceLow[0]) |=> !state_ff[0])
		else $error("bit zero reset case failed");

	// Variants: one clock for both, no clear when the halves stand alone
	a_shared_clk: assert property (@(posedge clock) disable iff (reset)
		sharedMode_ff |-> effClk[1] == clkS[0])
		else $error("shared clock not used");
	a_clk1_ignored: assert property (@(posedge clock) disable iff (reset)
		(sharedMode_ff && clkS[0] && !forceHigh[1] && !forceLow[1]) |=> $stable(qOut[1]))
		else $error("bit one followed its own clock pin");
	a_indiv_noclr: assert property (@(posedge clock) disable iff (reset)
		!sharedMode_ff |-> !forceLow[0] && !forceLow[1])
		else $error("clear active in individual variant");
	a_indep_bits: assert property (@(posedge clock) disable iff (reset)
		(!sharedMode_ff && fallEdge[0] && !fallEdge[1] && !forceHigh[1]) |=> $stable(qOut[1]))
		else $error("bit one moved with bit zero clock");

	c_toggle: cover property (@(posedge clock) disable iff (reset) fallEdge[0] && jS[0] && kS[0]);
	c_preset: cover property (@(posedge clock) disable iff (reset) forceHigh[1]);
	c_clear:  cover property (@(posedge clock) disable iff (reset) forceLow[0]);
	c_shared: cover property (@(posedge clock) disable iff (reset) sharedMode_ff && fallEdge[1]);
	c_hold:   cover property (@(posedge clock) disable iff (reset) fallEdge[0] && !jS[0] && !kS[0]);
endmodule

// *** verif/djk_pin_driver.sv ***
// Model of the logic that drives the pin clocks and the steering pins.
// Assumes the block samples the pins with the system clock through its synchronisers.
`timescale 1ns/100ps
module djk_pin_driver (
	// System
	input  wire logic       clock,
	input  wire logic       reset,
	// Request from the bench
	input  wire logic       start,
	input  wire logic [1:0] clkMask,
	input  wire logic [1:0] jReq,
	input  wire logic [1:0] kReq,
	// Pins
	output logic      [1:0] jIn,
	output logic      [1:0] kIn,
	output logic      [1:0] clkIn,
	output logic            done
);
	logic [3:0] cnt_ff;
	// Clock pins idle high so every pulse is armed before its falling edge
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			cnt_ff <= 4'h0;
			clkIn <= 2'h3;
			jIn   <= 2'h0;
			kIn   <= 2'h0;
			done  <= 1'b0;
		end else begin
			done <= 1'b0;
			if (cnt_ff == 4'h0 && start) begin
				jIn    <= jReq;
				kIn    <= kReq;
				cnt_ff <= 4'h1;
			end else if (cnt_ff != 4'h0) begin
				cnt_ff <= cnt_ff + 4'h1;
				if (cnt_ff == 4'h4) clkIn <= clkIn & ~clkMask;
				// Hold is over: steering flips so a late sample would show
				if (cnt_ff == 4'h8) begin
					clkIn <= 2'h3;
					jIn   <= ~jIn;
					kIn   <= ~kIn;
				end
				if (cnt_ff == 4'h9) begin
					done   <= 1'b1;
					cnt_ff <= 4'h0;
				end
			end
		end
	end
endmodule

// *** verif/djk_dual_flop_tb_top.sv ***
// Self-checking bench for the dual J-K bistable block, both variants.
// Assumes the pin driver model supplies clock pulses and steering values.
`timescale 1ns/100ps
module djk_dual_flop_tb_top;
	import djk_pkg::*;
	logic       clock, reset, variantShared, clearN, start, done;
	logic [1:0] jIn, kIn, clkIn, presetN, qOut, qOutN, clkMask, jReq, kReq, expQ;
	int         failCount, samplesChecked;
	djk_dual_flop djk_dual_flop_i (.clock(clock), .reset(reset), .variantShared(variantShared), .jIn(jIn),
		.kIn(kIn), .clkIn(clkIn), .presetN(presetN), .clearN(clearN), .qOut(qOut), .qOutN(qOutN));
	djk_pin_driver djk_pin_driver_i (.clock(clock), .reset(reset), .start(start), .clkMask(clkMask),
		.jReq(jReq), .kReq(kReq), .jIn(jIn), .kIn(kIn), .clkIn(clkIn), .done(done));
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	task automatic reportAndStop();
		$display("checks %0d mismatches %0d", samplesChecked, failCount);
		if (failCount == 0 && samplesChecked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic checkQ(input logic [1:0] exp);
		@(negedge clock);
		samplesChecked++;
		if (qOut !== exp || qOutN !== ~exp) begin
			failCount++;
			$display("Error at %0t: outputs %b/%b, expected %b", $time, qOut, qOutN, exp);
		end
		// Hand back on a rising edge so the next stimulus lands there
		@(posedge clock);
	endtask
	task automatic doReset(input logic shared);
		reset <= 1'b1;
		variantShared <= shared;
		repeat (6) @(posedge clock);
		reset <= 1'b0;
		repeat (3) @(posedge clock);
		expQ = 2'h0;
	endtask
	// One clock pulse on the masked pins; bounded wait for the model
	task automatic pulse(input logic [1:0] m, input logic [1:0] j, input logic [1:0] k);
		int i;
		clkMask <= m; jReq <= j; kReq <= k; start <= 1'b1;
		@(posedge clock);
		start <= 1'b0;
		for (i = 0; i < 20 && !done; i++) @(negedge clock);
		if (!done) begin
			failCount++;
			$display("Error at %0t: pin driver timed out", $time);
			reportAndStop();
		end
		repeat (2) @(posedge clock);
	endtask
	task automatic testTruthTable();
		logic [1:0] steps [6] = '{2'h2, 2'h0, 2'h3, 2'h3, 2'h1, 2'h0};
		for (int b = 0; b < 2; b++) begin
			foreach (steps[s]) begin
				// The other bistable sees toggle steering but no clock edge
				pulse(2'h1 << b, 2'h3 ^ ({1'b0, !steps[s][1]} << b), 2'h3 ^ ({1'b0, !steps[s][0]} << b));
				expQ[b] = steps[s] == 2'h3 ? ~expQ[b] : (steps[s] == 2'h0 ? expQ[b] : steps[s][1]);
				checkQ(expQ);
			end
		end
		$display("truth table test done");
	endtask
	task automatic testPresetIndiv();
		presetN <= 2'h2;
		repeat (5) @(posedge clock);
		checkQ(2'h1);
		pulse(2'h1, 2'h0, 2'h1);
		checkQ(2'h1);
		presetN <= 2'h3; clearN <= 1'b0;
		repeat (5) @(posedge clock);
		checkQ(2'h1);
		clearN <= 1'b1;
		pulse(2'h1, 2'h0, 2'h1);
		checkQ(2'h0);
		$display("preset test done");
	endtask
	task automatic testShared();
		doReset(1'b1);
		pulse(2'h1, 2'h1, 2'h2);
		checkQ(2'h1);
		pulse(2'h2, 2'h3, 2'h3);
		checkQ(2'h1);
		pulse(2'h1, 2'h3, 2'h3);
		checkQ(2'h2);
		clearN <= 1'b0;
		repeat (5) @(posedge clock);
		checkQ(2'h0);
		presetN <= 2'h1;
		repeat (5) @(posedge clock);
		checkQ(2'h2);
		presetN <= 2'h3; clearN <= 1'b1;
		$display("shared variant test done");
	endtask
	initial begin
		failCount = 0; samplesChecked = 0;
		reset = 1'b1; variantShared = 1'b0; clearN = 1'b1; presetN = 2'h3;
		start = 1'b0; clkMask = 2'h0; jReq = 2'h0; kReq = 2'h0;
		doReset(1'b0);
		testTruthTable();
		testPresetIndiv();
		testShared();
		reportAndStop();
	end
endmodule
